/* design/cpu_flags_and_working_reg_pointers.sv */
// status flags, current priority level and working register pointers
// Summary of operation
// - three bit priority level, 000 highest
// - compare request level against current level
// - preempted level saved in nested controller
// - flags pushed on entry, restored on return
// - flags reset zero, fixed bit order
// - carry from bit 7 or 15
// - set, clear, complement carry only
// - zero flag when result is zero
// - sign flag copies result top bit
// - overflow on signed range exceeded
// - decimal flag records add or subtract
// - half carry from bit 3 bytes
// - select data or program space flag
// - register file seen as 32 blocks
// - pointer instructions set mode and block
// - single mode ignores block low bit
// - single or twin working register mapping
// - group d not directly addressable
// - pointer a block, mode, zero bits
// - mode bit set twin, cleared single
// - pointer b holds upper eight block
`default_nettype none
module cpu_flags_and_working_reg_pointers
  import cpu_flags_pkg::*;
#(
  parameter int SAVE_DEPTH = FLAG_SAVE_DEPTH
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  // register file access port
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_direct,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_denied,
  // flag update from the alu
  input wire flag_op_e i_flag_op,
  input wire logic i_word_op,
  input wire logic i_is_sub,
  input wire logic i_bcd_op,
  input wire logic [15:0] i_result,
  input wire logic i_carry,
  input wire logic i_half_carry,
  input wire logic i_overflow,
  // pointer instructions
  input wire ptr_op_e i_ptr_op,
  input wire logic [4:0] i_ptr_block,
  // working register translation
  input wire logic [3:0] i_work_index,
  output logic [7:0] o_work_addr,
  // interrupt entry and return
  input wire logic i_irq_req,
  input wire logic [2:0] i_irq_level,
  input wire logic i_nested_mode,
  input wire logic i_irq_enter,
  input wire logic i_irq_return,
  input wire logic i_cpl_hw_wr,
  input wire logic [2:0] i_cpl_hw_data,
  output logic o_irq_preempt,
  output logic o_irq_pending,
  output logic [2:0] o_cpl,
  output logic [2:0] o_saved_cpl,
  output logic [7:0] o_status_flags,
  output logic o_data_space,
  output logic o_save_full
);
  // =====================================================
  // state
  // depth below one or above fifteen is refused
  if (SAVE_DEPTH < 1 || SAVE_DEPTH > 15) begin : g_depth_chk
    $error("SAVE_DEPTH out of range");
  end
  logic [7:0] flags_q;  // status flag register
  logic [2:0] cpl_q;  // current priority level
  logic [4:0] block_a_q;  // pointer a block number
  logic [4:0] block_b_q;  // pointer b block number
  logic twin_q;  // pointer mode select
  logic [7:0] rdata_q;  // read data register
  logic denied_q;  // direct group d access refused
  logic preempt_q;  // request allowed through
  logic pending_q;  // request left pending
  logic [7:0] work_addr_q;  // translated address
  logic [2:0] saved_cpl_q;  // last saved level
  logic [7:0] top_flags;  // flags at stack top
  logic [2:0] top_level;  // level at stack top
  logic stk_empty;  // no saved copy
  logic stk_full;  // saved copies all used
  logic [7:0] map_addr;  // combinational translation
  logic group_d;  // address is in group d
  logic wr_ok;  // register write accepted
  logic push_ok;  // interrupt entry accepted
  logic pop_ok;  // interrupt return accepted

  assign group_d = (i_reg_addr >= ADDR_GROUP_D_LO) &&
                   (i_reg_addr <= ADDR_GROUP_D_HI);
  assign wr_ok = i_reg_wr && !(i_reg_direct && group_d);
  assign push_ok = i_irq_enter && !stk_full;
  assign pop_ok = i_irq_return && !stk_empty;

  // =====================================================
  // saved flags and levels
  flag_save_stack #(
    .DEPTH(SAVE_DEPTH)
  ) u_stack (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_push(push_ok),
    .i_push_flags(flags_q),
    .i_push_level(cpl_q),
    .i_pop(i_irq_return),
    .o_top_flags(top_flags),
    .o_top_level(top_level),
    .o_empty(stk_empty),
    .o_full(stk_full)
  );

  // =====================================================
  // working register mapping
  working_reg_map u_map (
    .i_block_a(block_a_q),
    .i_block_b(block_b_q),
    .i_twin_mode(twin_q),
    .i_index(i_work_index),
    .o_addr(map_addr)
  );

  // =====================================================
  // status flags
  // priority: interrupt return, then register write, then alu op
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      flags_q <= STATUS_FLAGS_RST;
    end else if (pop_ok) begin
      flags_q <= top_flags;
      flags_q[FLAG_RSV] <= 1'b0;
    end else if (wr_ok && i_reg_addr == ADDR_STATUS_FLAGS) begin
      flags_q <= i_reg_wdata;
      flags_q[FLAG_RSV] <= 1'b0;
    end else begin
      unique case (i_flag_op)
        FOP_ARITH: begin
          flags_q[FLAG_C] <= i_carry;
          flags_q[FLAG_Z] <= i_word_op ? (i_result == 16'h0000)
                                       : (i_result[7:0] == 8'h00);
          flags_q[FLAG_S] <= i_word_op ? i_result[15]
                                       : i_result[7];
          flags_q[FLAG_V] <= i_overflow;
          if (i_bcd_op) begin
            flags_q[FLAG_DA] <= i_is_sub;
            if (!i_word_op) begin
              flags_q[FLAG_H] <= i_half_carry;
            end
          end
        end
        FOP_LOGIC: begin
          // logical, inc/dec and test leave carry alone
          flags_q[FLAG_Z] <= i_word_op ? (i_result == 16'h0000)
                                       : (i_result[7:0] == 8'h00);
          flags_q[FLAG_S] <= i_word_op ? i_result[15]
                                       : i_result[7];
          flags_q[FLAG_V] <= i_overflow;
        end
        FOP_CARRY_SET: flags_q[FLAG_C] <= 1'b1;
        FOP_CARRY_CLR: flags_q[FLAG_C] <= 1'b0;
        FOP_CARRY_CPL: flags_q[FLAG_C] <= ~flags_q[FLAG_C];
        FOP_SDM: flags_q[FLAG_DP] <= 1'b1;
        FOP_SPM: flags_q[FLAG_DP] <= 1'b0;
        default: ;  // no flag change
      endcase
    end
  end

  // =====================================================
  // current priority level
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      cpl_q <= PRIORITY_RST;
    end else if (pop_ok) begin
      cpl_q <= top_level;
    end else if (push_ok) begin
      cpl_q <= i_irq_level;
    end else if (i_cpl_hw_wr) begin
      cpl_q <= i_cpl_hw_data;
    end else if (wr_ok && i_reg_addr == ADDR_PRIORITY) begin
      cpl_q <= i_reg_wdata[2:0];
    end
  end

  // saved level seen by the nested controller
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      saved_cpl_q <= PRIORITY_RST;
    end else if (push_ok && i_nested_mode) begin
      saved_cpl_q <= cpl_q;
    end else if (pop_ok) begin
      saved_cpl_q <= top_level;
    end
  end

  // =====================================================
  // request arbitration against the current level
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      preempt_q <= 1'b0;
      pending_q <= 1'b0;
    end else begin
      preempt_q <= i_irq_req && (i_irq_level < cpl_q);
      pending_q <= i_irq_req && (i_irq_level >= cpl_q);
    end
  end

  // =====================================================
  // pointer registers
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      block_a_q <= BLOCK_RST;
      block_b_q <= BLOCK_RST;
      twin_q <= 1'b0;
    end else begin
      unique case (i_ptr_op)
        PTR_SINGLE: begin
          block_a_q <= i_ptr_block;
          twin_q <= 1'b0;
        end
        PTR_TWIN_A: begin
          block_a_q <= i_ptr_block;
          twin_q <= 1'b1;
        end
        PTR_TWIN_B: begin
          block_b_q <= i_ptr_block;
          twin_q <= 1'b1;
        end
        default: begin
          if (wr_ok && i_reg_addr == ADDR_POINTER_A) begin
            block_a_q <= i_reg_wdata[7:PTR_BLOCK_LSB];
            twin_q <= i_reg_wdata[PTR_MODE_BIT];
          end else if (wr_ok && i_reg_addr == ADDR_POINTER_B) begin
            block_b_q <= i_reg_wdata[7:PTR_BLOCK_LSB];
          end
        end
      endcase
    end
  end

  // =====================================================
  // register reads and refusal
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      rdata_q <= 8'h00;
      denied_q <= 1'b0;
    end else begin
      denied_q <= (i_reg_wr || i_reg_rd) && i_reg_direct && group_d;
      if (i_reg_rd) begin
        unique case (i_reg_addr)
          ADDR_STATUS_FLAGS: rdata_q <= flags_q;
          ADDR_PRIORITY: rdata_q <= {5'h00, cpl_q};
          ADDR_POINTER_A: rdata_q <= {block_a_q, twin_q, 2'b00};
          ADDR_POINTER_B: rdata_q <= {block_b_q, twin_q, 2'b00};
          default: rdata_q <= 8'h00;
        endcase
      end
    end
  end

  // registered translated address
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      work_addr_q <= 8'h00;
    end else begin
      work_addr_q <= map_addr;
    end
  end

  // =====================================================
  // outputs
  assign o_reg_rdata = rdata_q;
  assign o_reg_denied = denied_q;
  assign o_work_addr = work_addr_q;
  assign o_irq_preempt = preempt_q;
  assign o_irq_pending = pending_q;
  assign o_cpl = cpl_q;
  assign o_saved_cpl = saved_cpl_q;
  assign o_status_flags = flags_q;
  assign o_data_space = flags_q[FLAG_DP];
  assign o_save_full = stk_full;

  // =====================================================
  // checks
  default clocking cb_chk @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);
  // reset value seen on the first edge out of reset
  chk_flags_reset: assert property (
    $fell(i_rst) |-> flags_q == STATUS_FLAGS_RST)
    else $error("flags not zero after reset");
  chk_rsv_zero: assert property (
    !flags_q[FLAG_RSV])
    else $error("reserved flag bit set");
  chk_carry_set: assert property (
    (i_flag_op == FOP_CARRY_SET && !pop_ok && !wr_ok) |=>
      flags_q[FLAG_C] && $stable(flags_q[6:0]))
    else $error("set carry failed");
  chk_carry_cpl: assert property (
    (i_flag_op == FOP_CARRY_CPL && !pop_ok && !wr_ok) |=>
      flags_q[FLAG_C] != $past(flags_q[FLAG_C]))
    else $error("complement carry failed");
  chk_zero_byte: assert property (
    (i_flag_op == FOP_ARITH && !i_word_op && i_result[7:0] == 8'h00
     && !pop_ok && !wr_ok) |=> flags_q[FLAG_Z])
    else $error("zero flag not set");
  chk_sign_word: assert property (
    (i_flag_op == FOP_LOGIC && i_word_op && !pop_ok && !wr_ok) |=>
      flags_q[FLAG_S] == $past(i_result[15]))
    else $error("sign flag wrong");
  chk_twin_mode: assert property (
    (i_ptr_op == PTR_TWIN_B) |=> twin_q && block_b_q == $past(i_ptr_block))
    else $error("twin pointer not loaded");
  chk_single_map: assert property (
    !twin_q |=> work_addr_q == {$past(block_a_q[4:1]), $past(i_work_index)})
    else $error("single mode address wrong");
  // entry straight followed by return
  sequence s_enter;
    push_ok && !pop_ok;
  endsequence
  sequence s_leave;
    pop_ok && !push_ok;
  endsequence
  chk_flags_restore: assert property (
    s_enter ##1 s_leave |=> flags_q == $past(flags_q, 2))
    else $error("flags not restored");
  chk_preempt: assert property (
    (i_irq_req && i_irq_level < cpl_q) |=> o_irq_preempt && !o_irq_pending)
    else $error("preemption decision wrong");
endmodule
`default_nettype wire

/* design/flag_save_stack.sv */
// storage for status flag copies saved on interrupt entry
`default_nettype none
module flag_save_stack
  import cpu_flags_pkg::*;
#(
  parameter int DEPTH = FLAG_SAVE_DEPTH
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_push,
  input wire logic [7:0] i_push_flags,
  input wire logic [2:0] i_push_level,
  input wire logic i_pop,
  output logic [7:0] o_top_flags,
  output logic [2:0] o_top_level,
  output logic o_empty,
  output logic o_full
);
  // =====================================================
  // storage
  localparam int PW = $clog2(DEPTH + 1);
  // depth of zero leaves no room for a single copy
  if (DEPTH < 1) begin : g_depth_chk
    $error("flag_save_stack depth must be at least one");
  end
  logic [7:0] flags_mem [DEPTH];  // saved flags
  logic [2:0] level_mem [DEPTH];  // saved priority levels
  logic [PW-1:0] count_q;  // number of saved copies
  // push and pop bookkeeping
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      count_q <= '0;
    end else if (i_push && !o_full) begin
      count_q <= count_q + PW'(1);
    end else if (i_pop && !o_empty) begin
      count_q <= count_q - PW'(1);
    end
  end
  // write the new top entry
  always_ff @(posedge i_mclk) begin
    if (i_push && !o_full) begin
      flags_mem[count_q] <= i_push_flags;
      level_mem[count_q] <= i_push_level;
    end
  end
  assign o_empty = (count_q == '0);
  assign o_full = (count_q == PW'(DEPTH));
  // top of stack; flags zero and level at reset value when empty
  assign o_top_flags = o_empty ? 8'h00 : flags_mem[count_q - PW'(1)];
  assign o_top_level = o_empty ? PRIORITY_RST : level_mem[count_q - PW'(1)];
endmodule
`default_nettype wire

/* design/working_reg_map.sv */
// maps working register index onto a register file address
`default_nettype none
module working_reg_map
  import cpu_flags_pkg::*;
(
  input wire logic [4:0] i_block_a,
  input wire logic [4:0] i_block_b,
  input wire logic i_twin_mode,
  input wire logic [3:0] i_index,
  output logic [7:0] o_addr
);
  // =====================================================
  // address formation
  always_comb begin
    if (!i_twin_mode) begin
      // even block then 16 registers, low block bit dropped
      o_addr = {i_block_a[4:1], i_index};
    end else if (!i_index[3]) begin
      o_addr = {i_block_a, i_index[2:0]};
    end else begin
      o_addr = {i_block_b, i_index[2:0]};
    end
  end
endmodule
`default_nettype wire

/* inc/cpu_flags_pkg.sv */
// constants for the cpu flag and working register pointer block
`default_nettype none
package cpu_flags_pkg;
  // register file addresses of the system registers held here
  localparam logic [7:0] ADDR_PRIORITY = 8'he6;
  localparam logic [7:0] ADDR_STATUS_FLAGS = 8'he7;
  localparam logic [7:0] ADDR_POINTER_A = 8'he8;
  localparam logic [7:0] ADDR_POINTER_B = 8'he9;
  // first and last address of group d, reachable only by pointers
  localparam logic [7:0] ADDR_GROUP_D_LO = 8'hd0;
  localparam logic [7:0] ADDR_GROUP_D_HI = 8'hdf;
  // status flag bit positions
  localparam int FLAG_C = 7;
  localparam int FLAG_Z = 6;
  localparam int FLAG_S = 5;
  localparam int FLAG_V = 4;
  localparam int FLAG_DA = 3;
  localparam int FLAG_H = 2;
  localparam int FLAG_RSV = 1;
  localparam int FLAG_DP = 0;
  // reset values
  localparam logic [7:0] STATUS_FLAGS_RST = 8'h00;
  localparam logic [2:0] PRIORITY_RST = 3'h7;
  localparam logic [4:0] BLOCK_RST = 5'h00;
  // pointer register field positions
  localparam int PTR_BLOCK_LSB = 3;
  localparam int PTR_MODE_BIT = 2;
  // saved flag copies in nested mode
  localparam int FLAG_SAVE_DEPTH = 7;
  // flag operations requested by the instruction decoder
  typedef enum logic [3:0] {
    FOP_NONE, FOP_ARITH, FOP_LOGIC, FOP_CARRY_SET, FOP_CARRY_CLR,
    FOP_CARRY_CPL, FOP_SDM, FOP_SPM
  } flag_op_e;
  // working register pointer instructions
  typedef enum logic [1:0] {
    PTR_NONE, PTR_SINGLE, PTR_TWIN_A, PTR_TWIN_B
  } ptr_op_e;
endpackage
`default_nettype wire

/* verif/testbench.sv */
// self-checking bench for the flag and working pointer block
`default_nettype none
`define CHK(n, e, o) begin compares++; if ((e) !== (o)) begin \
  $display("MISMATCH %s exp %h got %h", n, e, o); err_total++; end end
module testbench
  import cpu_flags_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // stimulus and observed signals
  logic i_mclk, i_rst, i_reg_wr, i_reg_rd, i_reg_direct, i_word_op;
  logic i_is_sub, i_bcd_op, i_carry, i_half_carry, i_overflow;
  logic i_irq_req, i_nested_mode, i_irq_enter, i_irq_return;
  logic i_cpl_hw_wr, o_reg_denied, o_irq_preempt, o_irq_pending;
  logic o_data_space, o_save_full;
  logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, o_work_addr;
  logic [7:0] o_status_flags;
  logic [15:0] i_result;
  flag_op_e i_flag_op;
  ptr_op_e i_ptr_op;
  logic [4:0] i_ptr_block;
  logic [3:0] i_work_index;
  logic [2:0] i_irq_level, i_cpl_hw_data, o_cpl, o_saved_cpl;
  // scoreboard notes: which output, expected value, due cycle
  typedef struct {int sel; logic [7:0] exp; int due;} note_s;
  note_s notes[$];
  note_s n;
  string nm[10] = '{"rdata", "denied", "work_addr", "flags", "cpl",
    "saved_cpl", "preempt", "pending", "save_full", "data_space"};
  int err_total = 0;
  int compares = 0;
  int cyc = 0;
  int k;
  int seed;
  // reference state kept by the bench
  logic [7:0] fl, v;
  logic [2:0] c, sv;
  logic [4:0] ba, bb;
  logic tw;
  logic [7:0] fs[$];
  logic [2:0] cs[$];

  cpu_flags_and_working_reg_pointers #(.SAVE_DEPTH(FLAG_SAVE_DEPTH)) i_dut (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
    .i_reg_direct(i_reg_direct), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata), .o_reg_denied(o_reg_denied),
    .i_flag_op(i_flag_op), .i_word_op(i_word_op), .i_is_sub(i_is_sub),
    .i_bcd_op(i_bcd_op), .i_result(i_result), .i_carry(i_carry),
    .i_half_carry(i_half_carry), .i_overflow(i_overflow),
    .i_ptr_op(i_ptr_op), .i_ptr_block(i_ptr_block),
    .i_work_index(i_work_index), .o_work_addr(o_work_addr),
    .i_irq_req(i_irq_req), .i_irq_level(i_irq_level),
    .i_nested_mode(i_nested_mode), .i_irq_enter(i_irq_enter),
    .i_irq_return(i_irq_return), .i_cpl_hw_wr(i_cpl_hw_wr),
    .i_cpl_hw_data(i_cpl_hw_data), .o_irq_preempt(o_irq_preempt),
    .o_irq_pending(o_irq_pending), .o_cpl(o_cpl),
    .o_saved_cpl(o_saved_cpl), .o_status_flags(o_status_flags),
    .o_data_space(o_data_space), .o_save_full(o_save_full));

  // ==========================================================
  // clock, cycle count and output monitor
  initial i_mclk = 1'b0;
  always #12.5 i_mclk = ~i_mclk;
  always @(posedge i_mclk) cyc <= cyc + 1;
  // selects the output named by a note
  function automatic logic [7:0] obs(input int s);
    case (s)
      0: return o_reg_rdata;
      1: return {7'h00, o_reg_denied};
      2: return o_work_addr;
      3: return o_status_flags;
      4: return {5'h00, o_cpl};
      5: return {5'h00, o_saved_cpl};
      6: return {7'h00, o_irq_preempt};
      7: return {7'h00, o_irq_pending};
      8: return {7'h00, o_save_full};
      default: return {7'h00, o_data_space};
    endcase
  endfunction
  // takes due notes once the edge's updates have landed
  always @(posedge i_mclk) begin
    #2;
    while (notes.size() > 0 && notes[0].due <= cyc) begin
      n = notes.pop_front();
      `CHK(nm[n.sel], n.exp, obs(n.sel))
    end
  end

  // ==========================================================
  // driver tasks, all entered at a falling edge
  task automatic note(input int s, input logic [7:0] e);
    notes.push_back('{s, e, cyc + 1});
  endtask
  // drops every strobe, then waits one falling edge
  task automatic clr();
    i_reg_wr = 1'b0;
    i_reg_rd = 1'b0;
    i_flag_op = FOP_NONE;
    i_ptr_op = PTR_NONE;
    i_irq_req = 1'b0;
    i_irq_enter = 1'b0;
    i_irq_return = 1'b0;
    i_cpl_hw_wr = 1'b0;
    @(negedge i_mclk);
  endtask
  task automatic idle();
    @(negedge i_mclk);
    clr();
  endtask
  // register access; read data checked on our own registers only
  task automatic acc(input logic wr, input logic dir,
      input logic [7:0] a, input logic [7:0] d, input logic den);
    i_reg_wr = wr;
    i_reg_rd = !wr;
    i_reg_direct = dir;
    i_reg_addr = a;
    i_reg_wdata = d;
    note(1, {7'h00, den});
    if (!wr && !den && a >= ADDR_PRIORITY && a <= ADDR_POINTER_B)
      note(0, d);
    idle();
  endtask
  // pointer instruction, bench copy of the pointers follows
  task automatic ptr(input ptr_op_e op, input logic [4:0] b);
    i_ptr_op = op;
    i_ptr_block = b;
    if (op == PTR_TWIN_B) bb = b;
    else ba = b;
    tw = (op != PTR_SINGLE);
    idle();
    acc(0, 1, ADDR_POINTER_A, {ba, tw, 2'b00}, 0);
    acc(0, 1, ADDR_POINTER_B, {bb, tw, 2'b00}, 0);
  endtask
  // every working index translated against the bench mapping
  task automatic wk_all();
    logic [7:0] e;
    for (int x = 0; x < 16; x++) begin
      e = !tw ? {ba[4:1], 4'(x)} :
        (x[3] ? {bb, 3'(x)} : {ba, 3'(x)});
      i_work_index = 4'(x);
      note(2, e);
      idle();
    end
  endtask
  task automatic irq(input logic [2:0] l);
    i_irq_req = 1'b1;
    i_irq_level = l;
    note(6, {7'h00, l < c});
    note(7, {7'h00, !(l < c)});
    idle();
  endtask
  // entry; quick leaves the return free for the very next edge
  task automatic enter(input logic [2:0] l, input bit quick = 1'b0);
    i_irq_enter = 1'b1;
    i_irq_level = l;
    if (fs.size() < FLAG_SAVE_DEPTH) begin
      fs.push_back(fl);
      cs.push_back(c);
      if (i_nested_mode) sv = c;
      c = l;
    end
    note(5, {5'h00, sv});
    note(4, {5'h00, c});
    note(8, {7'h00, fs.size() == FLAG_SAVE_DEPTH});
    if (quick) begin
      @(negedge i_mclk);
      i_irq_enter = 1'b0;
    end else begin
      idle();
    end
  endtask
  // return; an empty stack leaves flags and level alone
  task automatic leave();
    i_irq_return = 1'b1;
    if (fs.size() > 0) begin
      fl = fs.pop_back();
      c = cs.pop_back();
      sv = c;
    end
    note(3, fl);
    note(4, {5'h00, c});
    note(5, {5'h00, sv});
    idle();
  endtask
  task automatic hw_cpl(input logic [2:0] l);
    i_cpl_hw_wr = 1'b1;
    i_cpl_hw_data = l;
    c = l;
    note(4, {5'h00, l});
    idle();
  endtask
  // closing: counts then verdict
  task automatic results();
    $display("counts: compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ==========================================================
  // watchdog, far beyond the few hundred cycles needed
  initial begin
    repeat (20000) @(posedge i_mclk);
    err_total++;
    results();
  end

  // ==========================================================
  // main sequence
  initial begin
    seed = $urandom(32'hd0d2b23e);
    {i_rst, i_reg_direct, i_word_op, i_is_sub} = 4'hf;
    {i_bcd_op, i_carry, i_half_carry, i_overflow} = 4'h0;
    {i_nested_mode, i_reg_wr, i_reg_rd, i_irq_req} = 4'h0;
    {i_irq_enter, i_irq_return, i_cpl_hw_wr} = 3'h0;
    {i_reg_addr, i_reg_wdata, i_result} = 32'h0;
    i_flag_op = FOP_NONE;
    i_ptr_op = PTR_NONE;
    {i_ptr_block, i_work_index} = 9'h000;
    {i_irq_level, i_cpl_hw_data} = 6'h00;
    {fl, c, ba, bb, tw} = {8'h00, 3'h7, 11'h000};
    sv = 3'h7;
    repeat (20) @(posedge i_mclk);
    @(negedge i_mclk);
    i_rst = 1'b0;
    @(negedge i_mclk);
    // reset state
    note(3, 8'h00);
    note(5, 8'h07);
    note(9, 8'h00);
    idle();
    acc(0, 1, ADDR_STATUS_FLAGS, 8'h00, 0);
    acc(0, 1, ADDR_PRIORITY, 8'h07, 0);
    $display("test reset done");
    // back-to-back arithmetic then logical results
    for (k = 0; k < 12; k++) begin
      i_flag_op = (k < 8) ? FOP_ARITH : FOP_LOGIC;
      i_result = 16'($urandom);
      {i_carry, i_half_carry, i_overflow, i_is_sub, i_word_op} =
        5'($urandom);
      if (k == 2) i_result = 16'h0000;
      if (k == 3) {i_result, i_word_op} = {16'hff00, 1'b0};
      if (k == 4) {i_result, i_word_op} = {16'h8000, 1'b1};
      if (k == 8) i_word_op = 1'b1;
      i_bcd_op = !i_word_op;
      if (k >= 8) {i_carry, i_overflow} = {~fl[FLAG_C], 1'b0};
      if (k < 8) fl[FLAG_C] = i_carry;
      fl[FLAG_Z] = i_word_op ? (i_result == 0) : (i_result[7:0] == 0);
      fl[FLAG_S] = i_word_op ? i_result[15] : i_result[7];
      fl[FLAG_V] = i_overflow;
      if (k < 8 && i_bcd_op) {fl[FLAG_DA], fl[FLAG_H]} =
        {i_is_sub, i_half_carry};
      note(3, fl);
      @(negedge i_mclk);
    end
    clr();
    $display("test alu flags done");
    // carry and space instructions, noise on the alu inputs
    for (k = 0; k < 8; k++) begin
      case (k)
        0, 3: i_flag_op = FOP_CARRY_SET;
        1, 4, 7: i_flag_op = FOP_CARRY_CPL;
        2: i_flag_op = FOP_CARRY_CLR;
        5: i_flag_op = FOP_SPM;
        default: i_flag_op = FOP_SDM;
      endcase
      {i_result, i_carry} = 17'($urandom);
      if (k == 0 || k == 3) fl[FLAG_C] = 1'b1;
      if (k == 2) fl[FLAG_C] = 1'b0;
      if (k == 1 || k == 4 || k == 7) fl[FLAG_C] = ~fl[FLAG_C];
      if (k >= 5) fl[FLAG_DP] = (k != 5);
      note(3, fl);
      note(9, {7'h00, fl[FLAG_DP]});
      @(negedge i_mclk);
    end
    clr();
    acc(1, 1, ADDR_STATUS_FLAGS, 8'hff, 0);
    fl = 8'hfd;
    acc(0, 1, ADDR_STATUS_FLAGS, fl, 0);
    $display("test carry and space done");
    // pointer modes and working register mapping
    ptr(PTR_SINGLE, 5'd3);
    wk_all();
    ptr(PTR_TWIN_A, 5'd5);
    ptr(PTR_TWIN_B, 5'($urandom));
    wk_all();
    ptr(PTR_SINGLE, 5'd31);
    wk_all();
    acc(1, 1, ADDR_POINTER_A, 8'h4b, 0);
    {ba, tw} = {5'd9, 1'b0};
    acc(0, 1, ADDR_POINTER_A, 8'h48, 0);
    wk_all();
    $display("test pointers done");
    // explicit access refused inside group d only
    acc(0, 1, 8'hcf, 8'h00, 0);
    acc(0, 1, ADDR_GROUP_D_LO, 8'h00, 1);
    acc(1, 1, 8'hd7, 8'h55, 1);
    acc(0, 1, ADDR_GROUP_D_HI, 8'h00, 1);
    acc(0, 0, ADDR_GROUP_D_LO, 8'h00, 0);
    acc(0, 1, 8'he0, 8'h00, 0);
    $display("test group d done");
    // priority level, preemption and a single entry
    hw_cpl(3'h4);
    acc(1, 1, ADDR_PRIORITY, 8'hff, 0);
    c = 3'h7;
    acc(0, 1, ADDR_PRIORITY, 8'h07, 0);
    hw_cpl(3'h3);
    for (k = 0; k < 8; k++) irq(3'(k));
    enter(3'h1);
    acc(1, 1, ADDR_STATUS_FLAGS, 8'h3c, 0);
    fl = 8'h3c;
    leave();
    $display("test priority done");
    // nested entries up to the save limit, one return too many
    i_nested_mode = 1'b1;
    hw_cpl(3'h7);
    for (k = 0; k < 7; k++) begin
      v = 8'($urandom) & 8'hfd;
      acc(1, 1, ADDR_STATUS_FLAGS, v, 0);
      fl = v;
      enter(3'(6 - k));
    end
    for (k = 0; k < 8; k++) leave();
    enter(3'h2, 1'b1);
    leave();
    $display("test nesting done");
    results();
  end
endmodule
`default_nettype wire
